// >>> dtsm_defines.svh
`ifndef DTSM_DEFINES_SVH
`define DTSM_DEFINES_SVH

// ==========================================================
// capability report
`define DTSM_CAP_PRESENT 1'b1
`define DTSM_THRESH_COUNT_DEF 2
`define DTSM_RESOLUTION_DEF 4'h1

// ==========================================================
// thermal_status_word bit positions
`define DTSM_ST_HOT 0
`define DTSM_ST_HOT_LOG 1
`define DTSM_ST_EVT 2
`define DTSM_ST_EVT_LOG 3
`define DTSM_ST_OOS 4
`define DTSM_ST_OOS_LOG 5
`define DTSM_ST_TH_BASE 6
`define DTSM_ST_TH_STRIDE 2
`define DTSM_ST_READ_LSB 16
`define DTSM_ST_READ_MSB 22
`define DTSM_ST_RES_LSB 27
`define DTSM_ST_RES_MSB 30
`define DTSM_ST_VALID 31

// ==========================================================
// thermal_interrupt_control bit positions
`define DTSM_IC_HI_EN 0
`define DTSM_IC_LO_EN 1
`define DTSM_IC_TRIP_EN 2
`define DTSM_IC_FP_EN 3
`define DTSM_IC_OH_EN 4
`define DTSM_IC_TH_LSB 8
`define DTSM_IC_TH_STRIDE 8
`define DTSM_IC_TH_EN_OFS 7

// ==========================================================
// reset values
`define DTSM_EN_RST 1'b0
`define DTSM_TH_RST 7'h00
`define DTSM_DATA_RST 64'h0000_0000_0000_0000

`endif

// >>> dtsm_pkg.sv
package dtsm_pkg;

    localparam int TEMP_W = 7;
    localparam int DATA_W = 64;

    typedef enum logic {
        DTSM_REG_STATUS,
        DTSM_REG_INTCTL
    } dtsm_reg_e;

    typedef struct packed {
        logic rd;
        logic wr;
        dtsm_reg_e sel;
        logic [DATA_W-1:0] wdata;
    } dtsm_msr_req_s;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] rdata;
    } dtsm_msr_rsp_s;

    typedef struct packed {
        logic [TEMP_W-1:0] readout;
        logic readout_valid;
        logic hot_indicator_signal;
        logic force_throttle_input;
        logic overheat;
        logic catastrophic_trip_signal;
    } dtsm_sensor_s;

endpackage

// >>> dtsm_monitor.sv
`timescale 1ns/1ps
`include "dtsm_defines.svh"

module dtsm_monitor #(
    parameter int THRESH_COUNT = `DTSM_THRESH_COUNT_DEF,
    parameter logic [3:0] RESOLUTION = `DTSM_RESOLUTION_DEF
) (
    input wire logic sys_clk_in, // core clock, 200 MHz
    input wire logic resetn_in, // async reset, active low
    input wire dtsm_pkg::dtsm_msr_req_s msr_req_in, // register access request
    input wire dtsm_pkg::dtsm_sensor_s sensor_in, // sensor and pin levels
    output dtsm_pkg::dtsm_msr_rsp_s msr_rsp_out, // read answer
    output logic cap_sensor_present_out, // capability: sensor present
    output logic [3:0] cap_threshold_count_out, // capability: thresholds
    output logic therm_irq_out, // interrupt request pulse
    output logic throttle_out, // throttle request level
    output logic shutdown_out // catastrophic shutdown level
);
    import dtsm_pkg::*;

    localparam int NTH = 2;

    // ======================================================
    // elaboration checks
    if (THRESH_COUNT < 1 || THRESH_COUNT > NTH)
    begin : g_bad_count
        $error("THRESH_COUNT must be 1 or 2");
    end

    // ======================================================
    // declarations
    dtsm_sensor_s sns_r;
    logic hot_prev_r;
    logic oos_prev_r;
    logic hot_log_r;
    logic evt_log_r;
    logic oos_log_r;
    logic hi_en_r;
    logic lo_en_r;
    logic trip_en_r;
    logic fp_en_r;
    logic oh_en_r;
    logic [TEMP_W-1:0] th_val_r [NTH];
    logic [NTH-1:0] th_en_r;
    logic [NTH-1:0] th_hit;
    logic [NTH-1:0] th_hit_r;
    logic [NTH-1:0] th_log_r;
    logic [NTH-1:0] th_irq;
    logic wr_status;
    logic wr_intctl;
    logic hot_rise;
    logic hot_fall;
    logic oos_rise;
    logic irq_nxt;
    logic clr_hot_log;
    logic clr_evt_log;
    logic clr_oos_log;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] intctl_word;

    assign wr_status = msr_req_in.wr && (msr_req_in.sel == DTSM_REG_STATUS);
    assign wr_intctl = msr_req_in.wr && (msr_req_in.sel == DTSM_REG_INTCTL);

    // a status write clears a log bit only where it writes a zero
    assign clr_hot_log = wr_status && !msr_req_in.wdata[`DTSM_ST_HOT_LOG];
    assign clr_evt_log = wr_status && !msr_req_in.wdata[`DTSM_ST_EVT_LOG];
    assign clr_oos_log = wr_status && !msr_req_in.wdata[`DTSM_ST_OOS_LOG];

    // ======================================================
    // capability report
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cap_sensor_present_out <= 1'b0;
            cap_threshold_count_out <= 4'h0;
        end
        else
        begin
            cap_sensor_present_out <= `DTSM_CAP_PRESENT;
            cap_threshold_count_out <= 4'(THRESH_COUNT);
        end
    end

    // ======================================================
    // sensor sampling and edge history
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sns_r <= '0;
            hot_prev_r <= 1'b0;
            oos_prev_r <= 1'b0;
        end
        else
        begin
            sns_r <= sensor_in;
            hot_prev_r <= sns_r.hot_indicator_signal;
            oos_prev_r <= sns_r.overheat;
        end
    end

    assign hot_rise = sns_r.hot_indicator_signal && !hot_prev_r;
    assign hot_fall = !sns_r.hot_indicator_signal && hot_prev_r;
    assign oos_rise = sns_r.overheat && !oos_prev_r;

    // ======================================================
    // sticky logs: a set in the clearing cycle wins, so an
    // event that lands on a software clear is never lost
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hot_log_r <= 1'b0;
        end
        else
        begin
            hot_log_r <= (hot_log_r && !clr_hot_log)
                || sns_r.hot_indicator_signal;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            evt_log_r <= 1'b0;
        end
        else
        begin
            evt_log_r <= (evt_log_r && !clr_evt_log)
                || sns_r.hot_indicator_signal || sns_r.force_throttle_input;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            oos_log_r <= 1'b0;
        end
        else
        begin
            oos_log_r <= (oos_log_r && !clr_oos_log)
                || sns_r.overheat;
        end
    end

    // ======================================================
    // interrupt control register
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            hi_en_r <= `DTSM_EN_RST;
            lo_en_r <= `DTSM_EN_RST;
            trip_en_r <= `DTSM_EN_RST;
            fp_en_r <= `DTSM_EN_RST;
            oh_en_r <= `DTSM_EN_RST;
        end
        else if (wr_intctl)
        begin
            hi_en_r <= msr_req_in.wdata[`DTSM_IC_HI_EN];
            lo_en_r <= msr_req_in.wdata[`DTSM_IC_LO_EN];
            trip_en_r <= msr_req_in.wdata[`DTSM_IC_TRIP_EN];
            fp_en_r <= msr_req_in.wdata[`DTSM_IC_FP_EN];
            oh_en_r <= msr_req_in.wdata[`DTSM_IC_OH_EN];
        end
    end

    // ======================================================
    // per-threshold value, compare, log and crossing
    // readout counts down as the die heats, so "at or above"
    // the threshold temperature means readout <= value
    for (genvar i = 0; i < NTH; i++)
    begin : g_th
        localparam int VLSB = `DTSM_IC_TH_LSB + i * `DTSM_IC_TH_STRIDE;
        localparam int ENB = VLSB + `DTSM_IC_TH_EN_OFS;
        localparam int LOGB = `DTSM_ST_TH_BASE + i * `DTSM_ST_TH_STRIDE + 1;
        localparam bit USED = (i < THRESH_COUNT);

        always_ff @(posedge sys_clk_in or negedge resetn_in)
        begin
            if (!resetn_in)
            begin
                th_val_r[i] <= `DTSM_TH_RST;
                th_en_r[i] <= `DTSM_EN_RST;
            end
            else if (wr_intctl && USED)
            begin
                th_val_r[i] <= msr_req_in.wdata[VLSB +: TEMP_W];
                th_en_r[i] <= msr_req_in.wdata[ENB];
            end
        end

        // an invalid reading holds the last compare result
        assign th_hit[i] = USED && (sns_r.readout_valid
            ? (sns_r.readout <= th_val_r[i]) : th_hit_r[i]);

        always_ff @(posedge sys_clk_in or negedge resetn_in)
        begin
            if (!resetn_in)
            begin
                th_hit_r[i] <= 1'b0;
                th_log_r[i] <= 1'b0;
            end
            else
            begin
                th_hit_r[i] <= th_hit[i];
                th_log_r[i] <= (th_log_r[i] && !(wr_status && !msr_req_in.wdata[LOGB]))
                    || th_hit[i];
            end
        end

        // both directions count as a crossing
        assign th_irq[i] = th_en_r[i] && (th_hit[i] != th_hit_r[i]);
    end

    // ======================================================
    // interrupt, throttle and shutdown outputs
    assign irq_nxt = (hi_en_r && hot_rise)
        || (lo_en_r && hot_fall)
        || (oh_en_r && oos_rise)
        || (|th_irq);

    // registered so the request is a clean one-cycle pulse
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            therm_irq_out <= 1'b0;
        end
        else
        begin
            therm_irq_out <= irq_nxt;
        end
    end

    // an external hot assertion only throttles when allowed
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            throttle_out <= 1'b0;
        end
        else
        begin
            throttle_out <= fp_en_r && sns_r.hot_indicator_signal;
        end
    end

    // shutdown is held until reset: the die cannot be trusted
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            shutdown_out <= 1'b0;
        end
        else
        begin
            shutdown_out <= shutdown_out
                || (trip_en_r && sns_r.catastrophic_trip_signal);
        end
    end

    // ======================================================
    // readback words; reserved bits read zero
    always_comb
    begin
        status_word = '0;
        status_word[`DTSM_ST_HOT] = sns_r.hot_indicator_signal;
        status_word[`DTSM_ST_HOT_LOG] = hot_log_r;
        status_word[`DTSM_ST_EVT] = sns_r.hot_indicator_signal
            || sns_r.force_throttle_input;
        status_word[`DTSM_ST_EVT_LOG] = evt_log_r;
        status_word[`DTSM_ST_OOS] = sns_r.overheat;
        status_word[`DTSM_ST_OOS_LOG] = oos_log_r;
        for (int k = 0; k < NTH; k++)
        begin
            status_word[`DTSM_ST_TH_BASE + k * `DTSM_ST_TH_STRIDE] = th_hit_r[k];
            status_word[`DTSM_ST_TH_BASE + k * `DTSM_ST_TH_STRIDE + 1] = th_log_r[k];
        end
        status_word[`DTSM_ST_READ_MSB:`DTSM_ST_READ_LSB] = sns_r.readout;
        status_word[`DTSM_ST_RES_MSB:`DTSM_ST_RES_LSB] = RESOLUTION;
        status_word[`DTSM_ST_VALID] = sns_r.readout_valid;
    end

    always_comb
    begin
        intctl_word = '0;
        intctl_word[`DTSM_IC_HI_EN] = hi_en_r;
        intctl_word[`DTSM_IC_LO_EN] = lo_en_r;
        intctl_word[`DTSM_IC_TRIP_EN] = trip_en_r;
        intctl_word[`DTSM_IC_FP_EN] = fp_en_r;
        intctl_word[`DTSM_IC_OH_EN] = oh_en_r;
        for (int k = 0; k < NTH; k++)
        begin
            intctl_word[`DTSM_IC_TH_LSB + k * `DTSM_IC_TH_STRIDE +: TEMP_W] = th_val_r[k];
            intctl_word[`DTSM_IC_TH_LSB + k * `DTSM_IC_TH_STRIDE + `DTSM_IC_TH_EN_OFS]
                = th_en_r[k];
        end
    end

    // ======================================================
    // read answer, one cycle after the request
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            msr_rsp_out.valid <= 1'b0;
            msr_rsp_out.rdata <= `DTSM_DATA_RST;
        end
        else
        begin
            msr_rsp_out.valid <= msr_req_in.rd;
            if (msr_req_in.rd)
            begin
                unique case (msr_req_in.sel)
                    DTSM_REG_STATUS: msr_rsp_out.rdata <= status_word;
                    DTSM_REG_INTCTL: msr_rsp_out.rdata <= intctl_word;
                endcase
            end
        end
    end

endmodule // dtsm_monitor

// >>> dtsm_check_monitor.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the thermal monitor
module dtsm_check_monitor #(
    parameter int THRESH_COUNT = 2,
    parameter logic [3:0] RESOLUTION = 4'h1
) (
    input wire logic sys_clk_in, // core clock
    input wire logic resetn_in, // async reset
    input wire dtsm_pkg::dtsm_msr_req_s msr_req_in, // access request
    input wire dtsm_pkg::dtsm_sensor_s sensor_in, // sensor levels
    input wire dtsm_pkg::dtsm_msr_rsp_s msr_rsp_out, // read answer
    input wire logic cap_sensor_present_out, // capability bit
    input wire logic [3:0] cap_threshold_count_out, // capability count
    input wire logic therm_irq_out, // interrupt pulse
    input wire logic throttle_out, // throttle level
    input wire logic shutdown_out // shutdown level
);
    import dtsm_pkg::*;
    // shadow of the control word, so irq gating can be judged from ports alone
    logic [23:0] ctl_r;
    logic en_any;
    always_ff @(posedge sys_clk_in or negedge resetn_in)
        if (!resetn_in)
            ctl_r <= 24'h00_0000;
        else if (msr_req_in.wr && msr_req_in.sel == DTSM_REG_INTCTL)
            ctl_r <= msr_req_in.wdata[23:0];
    assign en_any = |{ctl_r[23], ctl_r[15], ctl_r[4], ctl_r[1:0]};
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    property live_bit_p(logic src, int pos);
        msr_req_in.rd && msr_req_in.sel == DTSM_REG_STATUS && $stable(src)
            |=> msr_rsp_out.rdata[pos] == $past(src);
    endproperty
    cap_report_a: assert property ($past(resetn_in) |-> cap_sensor_present_out
        && cap_threshold_count_out == THRESH_COUNT) else $error("capability wrong");
    hot_live_a: assert property (live_bit_p(sensor_in.hot_indicator_signal, 0))
        else $error("hot flag wrong");
    evt_live_a: assert property (live_bit_p(sensor_in.hot_indicator_signal
        | sensor_in.force_throttle_input, 2)) else $error("event flag wrong");
    oos_live_a: assert property (live_bit_p(sensor_in.overheat, 4))
        else $error("out of spec flag wrong");
    valid_flag_a: assert property (live_bit_p(sensor_in.readout_valid, 31))
        else $error("valid flag wrong");
    status_const_a: assert property (msr_rsp_out.valid && $past(msr_req_in.sel) ==
        DTSM_REG_STATUS |-> msr_rsp_out.rdata[30:27] == RESOLUTION) else $error("resolution");
    irq_gate_a: assert property (therm_irq_out |-> $past(en_any) || $past(en_any, 2)
        || $past(en_any, 3)) else $error("irq while disabled");
    quiet_irq_a: assert property ((!msr_req_in.wr && $stable(sensor_in))[*6]
        |-> !therm_irq_out) else $error("irq without a crossing");
    hi_irq_a: assert property ($rose(sensor_in.hot_indicator_signal) && ctl_r[0]
        |-> ##[1:3] therm_irq_out) else $error("no high irq");
    lo_irq_a: assert property ($fell(sensor_in.hot_indicator_signal) && ctl_r[1]
        |-> ##[1:3] therm_irq_out) else $error("no low irq");
    throttle_a: assert property (($stable(sensor_in.hot_indicator_signal)
        && $stable(ctl_r[3]))[*3] |-> throttle_out == (ctl_r[3]
        && sensor_in.hot_indicator_signal)) else $error("throttle wrong");
    shutdown_a: assert property (ctl_r[2] && sensor_in.catastrophic_trip_signal
        |-> ##[1:3] shutdown_out) else $error("no shutdown");
    irq_c: cover property (therm_irq_out);
    throttle_c: cover property (throttle_out);
    shutdown_c: cover property (shutdown_out);
endmodule // dtsm_check_monitor

bind dtsm_monitor dtsm_check_monitor #(.THRESH_COUNT(THRESH_COUNT),
    .RESOLUTION(RESOLUTION)) dtsm_check_monitor_inst (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .msr_req_in(msr_req_in), .sensor_in(sensor_in),
    .msr_rsp_out(msr_rsp_out), .cap_sensor_present_out(cap_sensor_present_out),
    .cap_threshold_count_out(cap_threshold_count_out), .therm_irq_out(therm_irq_out),
    .throttle_out(throttle_out), .shutdown_out(shutdown_out));

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    import dtsm_pkg::*;
    // non-default resolution so a hard-wired field shows up
    localparam logic [3:0] RES = 4'h3;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    dtsm_msr_req_s req = '0;
    dtsm_sensor_s sns = '0;
    dtsm_sensor_s cur = '0;
    dtsm_msr_rsp_s rsp;
    logic cap_p, irq, thr, sdn;
    logic [3:0] cap_n;
    logic [63:0] rdat;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_irq = 0;
    int e_irq = 0;
    logic [6:0] tr [4] = '{7'h10, 7'h05, 7'h0A, 7'h30};
    logic [3:0] ts [4] = '{4'h3, 4'hF, 4'hB, 4'hA};
    dtsm_monitor #(.THRESH_COUNT(2), .RESOLUTION(RES)) dtsm_monitor_inst (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .msr_req_in(req),
        .sensor_in(sns), .msr_rsp_out(rsp), .cap_sensor_present_out(cap_p),
        .cap_threshold_count_out(cap_n), .therm_irq_out(irq), .throttle_out(thr),
        .shutdown_out(sdn));
    always #2.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (irq === 1'b1) n_irq <= n_irq + 1;
    // ==========================================
    // access tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rd(input dtsm_reg_e s);
        int i;
        @(posedge sys_clk_in);
        req.rd <= 1'b1;
        req.sel <= s;
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
        i = 0;
        @(negedge sys_clk_in);
        while (rsp.valid !== 1'b1 && i < 4)
        begin
            @(negedge sys_clk_in);
            i++;
        end
        if (i == 4)
        begin
            n_mismatch++;
            close_out();
        end
        else
        begin
            rdat = rsp.rdata;
        end
    endtask
    task automatic wr(input dtsm_reg_e s, input logic [63:0] d);
        @(posedge sys_clk_in);
        req.wr <= 1'b1;
        req.sel <= s;
        req.wdata <= d;
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask
    task automatic apply();
        @(posedge sys_clk_in);
        sns <= cur;
        repeat (5) @(posedge sys_clk_in);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        repeat (4) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk({cap_p, cap_n}, {1'b1, 4'h2});
        rd(DTSM_REG_STATUS);
        chk(rdat, {33'h0, RES, 27'h0});
        rd(DTSM_REG_INTCTL);
        chk(rdat, 64'h0);
        wr(DTSM_REG_INTCTL, '1);
        rd(DTSM_REG_INTCTL);
        chk(rdat, 24'hFF_FF1F);
        wr(DTSM_REG_INTCTL, 64'h0);
        cur.hot_indicator_signal = 1'b1;
        apply();
        rd(DTSM_REG_STATUS);
        chk(rdat[5:0], 6'h0F);
        wr(DTSM_REG_STATUS, '1);
        cur.hot_indicator_signal = 1'b0;
        apply();
        rd(DTSM_REG_STATUS);
        chk(rdat[5:0], 6'h0A);
        wr(DTSM_REG_STATUS, 64'h0);
        cur.force_throttle_input = 1'b1;
        cur.overheat = 1'b1;
        apply();
        rd(DTSM_REG_STATUS);
        chk(rdat[5:0], 6'h3C);
        cur.force_throttle_input = 1'b0;
        cur.overheat = 1'b0;
        apply();
        wr(DTSM_REG_STATUS, 64'h0);
        rd(DTSM_REG_STATUS);
        chk(rdat[9:0], 10'h000);
        chk(64'(n_irq), 64'h0);
        cur.readout_valid = 1'b1;
        cur.readout = 7'h2A;
        apply();
        rd(DTSM_REG_STATUS);
        chk({rdat[31], rdat[22:16]}, {1'b1, 7'h2A});
        // both thresholds sit well clear of the present reading
        wr(DTSM_REG_INTCTL, 24'h85_9000);
        for (int k = 0; k < 4; k++)
        begin
            cur.readout = tr[k];
            apply();
            e_irq++;
            rd(DTSM_REG_STATUS);
            chk(rdat[9:6], ts[k]);
            chk(64'(n_irq), 64'(e_irq));
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(DTSM_REG_INTCTL, 64'(1 << k));
            cur.hot_indicator_signal = 1'b1;
            apply();
            e_irq += (k == 0);
            chk(64'(n_irq), 64'(e_irq));
            cur.hot_indicator_signal = 1'b0;
            apply();
            e_irq += (k == 1);
            chk(64'(n_irq), 64'(e_irq));
        end
        wr(DTSM_REG_INTCTL, 64'h10);
        cur.overheat = 1'b1;
        apply();
        e_irq++;
        cur.overheat = 1'b0;
        apply();
        chk(64'(n_irq), 64'(e_irq));
        wr(DTSM_REG_INTCTL, 64'h8);
        cur.hot_indicator_signal = 1'b1;
        apply();
        @(negedge sys_clk_in);
        chk(thr, 1'b1);
        wr(DTSM_REG_INTCTL, 64'h4);
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk(thr, 1'b0);
        cur.catastrophic_trip_signal = 1'b1;
        apply();
        cur.catastrophic_trip_signal = 1'b0;
        apply();
        chk(sdn, 1'b1);
        chk(64'(n_irq), 64'(e_irq));
        close_out();
    end
endmodule // testbench
